// file: hied_pkg.sv
// Functional notes
// - Each interface descriptor is nine bytes long, type 04h, hub class 09h, subclass 00h.
// - Byte 2 of every interface descriptor carries interface number 00h in both variants.
// - Byte 3 carries alternate setting 00h for single-translator and 01h for multi.
// - Each interface descriptor declares one endpoint besides the control endpoint.
// - Protocol is 00h for single-translator with one interface and 02h for multi.
// - Protocol of the single-translator interface is 01h when two interfaces are reported.
// - Byte 8 of each interface descriptor is string index 00h.
// - The status-change endpoint descriptor is seven bytes long with type 05h in both sets.
// - The status-change endpoint address is 81h, endpoint one toward the host.
// - Endpoint attributes are 03h, interrupt transfer with no synchronisation.
// - Maximum packet size is 0001h at byte offset 4 of the endpoint descriptor.
// - Polling interval is 0Ch at byte offset 6 of the endpoint descriptor.
// - The multi-translator descriptor pair is returned only when multi-translator is selected.
// - Configuration total length is 0019h without and 0029h with multi-translator support.
package hied_pkg;

  // Descriptor field values
  localparam logic [7:0] HIED_IF_LEN = 8'h09;
  localparam logic [7:0] HIED_IF_TYPE = 8'h04;
  localparam logic [7:0] HIED_IF_NUMBER = 8'h00;
  localparam logic [7:0] HIED_ALT_SINGLE = 8'h00;
  localparam logic [7:0] HIED_ALT_MULTI = 8'h01;
  localparam logic [7:0] HIED_NUM_EP = 8'h01;
  localparam logic [7:0] HIED_HUB_CLASS = 8'h09;
  localparam logic [7:0] HIED_SUBCLASS = 8'h00;
  localparam logic [7:0] HIED_PROTO_SINGLE_ONE = 8'h00;
  localparam logic [7:0] HIED_PROTO_SINGLE_TWO = 8'h01;
  localparam logic [7:0] HIED_PROTO_MULTI = 8'h02;
  localparam logic [7:0] HIED_IF_STRING = 8'h00;
  localparam logic [7:0] HIED_EP_LEN = 8'h07;
  localparam logic [7:0] HIED_EP_TYPE = 8'h05;
  localparam logic [7:0] HIED_EP_ADDR = 8'h81;
  localparam logic [7:0] HIED_EP_ATTR = 8'h03;
  localparam logic [15:0] HIED_EP_MAXPKT = 16'h0001;
  localparam logic [7:0] HIED_EP_INTERVAL = 8'h0c;

  // Configuration total length
  localparam logic [15:0] HIED_TOTAL_SINGLE = 16'h0019;
  localparam logic [15:0] HIED_TOTAL_MULTI = 16'h0029;

  // Byte offsets inside each descriptor
  localparam logic [3:0] HIED_OFF_LEN = 4'h0;
  localparam logic [3:0] HIED_OFF_TYPE = 4'h1;
  localparam logic [3:0] HIED_OFF_IFNUM = 4'h2;
  localparam logic [3:0] HIED_OFF_ALT = 4'h3;
  localparam logic [3:0] HIED_OFF_NUMEP = 4'h4;
  localparam logic [3:0] HIED_OFF_CLASS = 4'h5;
  localparam logic [3:0] HIED_OFF_SUBCLASS = 4'h6;
  localparam logic [3:0] HIED_OFF_PROTO = 4'h7;
  localparam logic [3:0] HIED_OFF_STRING = 4'h8;
  localparam logic [3:0] HIED_OFF_EPADDR = 4'h2;
  localparam logic [3:0] HIED_OFF_ATTR = 4'h3;
  localparam logic [3:0] HIED_OFF_MAXPKT_LO = 4'h4;
  localparam logic [3:0] HIED_OFF_MAXPKT_HI = 4'h5;
  localparam logic [3:0] HIED_OFF_INTERVAL = 4'h6;

  // Layout of the stream that follows the configuration header
  localparam logic [5:0] HIED_SET_LEN = 6'h10;
  localparam logic [5:0] HIED_TAIL_SINGLE = 6'h10;
  localparam logic [5:0] HIED_TAIL_MULTI = 6'h20;

  // Values after reset
  localparam logic [7:0] HIED_RST_BYTE = 8'h00;
  localparam logic [5:0] HIED_RST_IDX = 6'h00;
  localparam logic [7:0] HIED_RST_REM = 8'h00;

endpackage : hied_pkg

// file: hied_desc_rom.sv
`timescale 1ns/1ps
module hied_desc_rom
  import hied_pkg::*;
(
  input wire logic [5:0] idx_i,
  input wire logic two_interfaces_i,
  output logic [7:0] data_o
);

  logic multi_set;
  logic [3:0] pos;
  logic in_ep;
  logic [3:0] ep_pos;

  assign multi_set = idx_i[4];
  assign pos = idx_i[3:0];
  assign in_ep = (pos > HIED_OFF_STRING);
  assign ep_pos = pos - 4'h9;

  always_comb
  begin
    data_o = 8'h00;
    if (!in_ep)
    begin
      unique case (pos)
        HIED_OFF_LEN: data_o = HIED_IF_LEN;
        HIED_OFF_TYPE: data_o = HIED_IF_TYPE;
        HIED_OFF_IFNUM: data_o = HIED_IF_NUMBER;
        HIED_OFF_ALT: data_o = multi_set ? HIED_ALT_MULTI : HIED_ALT_SINGLE;
        HIED_OFF_NUMEP: data_o = HIED_NUM_EP;
        HIED_OFF_CLASS: data_o = HIED_HUB_CLASS;
        HIED_OFF_SUBCLASS: data_o = HIED_SUBCLASS;
        HIED_OFF_PROTO:
        begin
          if (multi_set)
            data_o = HIED_PROTO_MULTI;
          else if (two_interfaces_i)
            data_o = HIED_PROTO_SINGLE_TWO;
          else
            data_o = HIED_PROTO_SINGLE_ONE;
        end
        HIED_OFF_STRING: data_o = HIED_IF_STRING;
        default: data_o = 8'h00;
      endcase
    end
    else
    begin
      unique case (ep_pos)
        HIED_OFF_LEN: data_o = HIED_EP_LEN;
        HIED_OFF_TYPE: data_o = HIED_EP_TYPE;
        HIED_OFF_EPADDR: data_o = HIED_EP_ADDR;
        HIED_OFF_ATTR: data_o = HIED_EP_ATTR;
        HIED_OFF_MAXPKT_LO: data_o = HIED_EP_MAXPKT[7:0];
        HIED_OFF_MAXPKT_HI: data_o = HIED_EP_MAXPKT[15:8];
        HIED_OFF_INTERVAL: data_o = HIED_EP_INTERVAL;
        default: data_o = 8'h00;
      endcase
    end
  end

endmodule : hied_desc_rom

// file: hied_desc_source.sv
`timescale 1ns/1ps
module hied_desc_source
  import hied_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic multi_translator_select_i,
  input wire logic two_interfaces_i,
  input wire logic start_i,
  input wire logic [5:0] skip_i,
  input wire logic [7:0] max_len_i,
  input wire logic abort_i,
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic byte_last_o,
  output logic busy_o,
  output logic [15:0] total_length_o
);

  typedef enum logic [0:0] {HIED_IDLE, HIED_SEND} hied_state_t;

  hied_state_t state;
  hied_state_t next_state;
  logic [5:0] idx;
  logic [5:0] next_idx;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [5:0] tail_len;
  logic [5:0] next_tail_len;
  logic two_if;
  logic next_two_if;
  logic next_valid;
  logic next_last;
  logic [15:0] next_total;
  logic [7:0] rom_byte;
  logic [5:0] start_tail;

  assign start_tail = multi_translator_select_i ? HIED_TAIL_MULTI : HIED_TAIL_SINGLE;

  hied_desc_rom u_rom (
    .idx_i(next_idx),
    .two_interfaces_i(next_two_if),
    .data_o(rom_byte)
  );

  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_remain = remain;
    next_tail_len = tail_len;
    next_two_if = two_if;
    next_valid = byte_valid_o;
    next_last = byte_last_o;
    next_total = multi_translator_select_i ? HIED_TOTAL_MULTI : HIED_TOTAL_SINGLE;
    unique case (state)
      HIED_IDLE:
      begin
        if (start_i && (max_len_i != 8'h00) && (skip_i < start_tail))
        begin
          next_state = HIED_SEND;
          next_idx = skip_i;
          next_remain = max_len_i;
          next_tail_len = start_tail;
          next_two_if = two_interfaces_i;
          next_valid = 1'b1;
          next_last = (max_len_i == 8'h01) || (skip_i == start_tail - 6'h01);
        end
      end
      HIED_SEND:
      begin
        if (abort_i)
        begin
          next_state = HIED_IDLE;
          next_valid = 1'b0;
          next_last = 1'b0;
        end
        else if (byte_ready_i)
        begin
          if (byte_last_o)
          begin
            next_state = HIED_IDLE;
            next_valid = 1'b0;
            next_last = 1'b0;
          end
          else
          begin
            next_idx = idx + 6'h01;
            next_remain = remain - 8'h01;
            next_last = (remain == 8'h02) || (idx + 6'h02 == tail_len);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= HIED_IDLE;
      idx <= HIED_RST_IDX;
      remain <= HIED_RST_REM;
      tail_len <= HIED_TAIL_SINGLE;
      two_if <= 1'b0;
      byte_valid_o <= 1'b0;
      byte_last_o <= 1'b0;
      byte_data_o <= HIED_RST_BYTE;
      busy_o <= 1'b0;
      total_length_o <= HIED_TOTAL_SINGLE;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      remain <= next_remain;
      tail_len <= next_tail_len;
      two_if <= next_two_if;
      byte_valid_o <= next_valid;
      byte_last_o <= next_last;
      byte_data_o <= next_valid ? rom_byte : HIED_RST_BYTE;
      busy_o <= (next_state == HIED_SEND);
      total_length_o <= next_total;
    end
  end

endmodule : hied_desc_source

// file: hied_desc_source_asserts.sv
`timescale 1ns/1ps
module hied_desc_source_chk
  import hied_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic multi_translator_select_i,
  input wire logic start_i,
  input wire logic [5:0] skip_i,
  input wire logic [7:0] max_len_i,
  input wire logic abort_i,
  input wire logic byte_ready_i,
  input wire logic byte_valid_o,
  input wire logic [7:0] byte_data_o,
  input wire logic byte_last_o,
  input wire logic busy_o,
  input wire logic [15:0] total_length_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic take;
  assign take = start_i && !busy_o && max_len_i != 8'h00
    && skip_i < (multi_translator_select_i ? HIED_TAIL_MULTI : HIED_TAIL_SINGLE);
  property p_tot; !$past(srst_i) |-> total_length_o ==
    ($past(multi_translator_select_i) ? HIED_TOTAL_MULTI : HIED_TOTAL_SINGLE); endproperty
  a_tot: assert property (p_tot) else $error("bad total");
  property p_first; take && skip_i == 6'h00 |=> byte_data_o == 8'h09; endproperty
  a_first: assert property (p_first) else $error("bad first");
  property p_take; take |=> byte_valid_o && busy_o; endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_hold; byte_valid_o && !byte_ready_i && !abort_i |=> byte_valid_o
    && $stable(byte_data_o) && $stable(byte_last_o); endproperty
  a_hold: assert property (p_hold) else $error("not held");
  property p_last; byte_valid_o && byte_ready_i && byte_last_o |=> !byte_valid_o; endproperty
  a_last: assert property (p_last) else $error("no gap");
  property p_abort; byte_valid_o && abort_i |=> !byte_valid_o; endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_refuse; start_i && !busy_o && !multi_translator_select_i
    && skip_i >= HIED_TAIL_SINGLE |=> !byte_valid_o; endproperty
  a_refuse: assert property (p_refuse) else $error("not refused");
  property p_idle; !byte_valid_o |-> byte_data_o == 8'h00 && !byte_last_o && !busy_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle dirty");
  c_multi: cover property (take && multi_translator_select_i);
  c_abort: cover property (byte_valid_o && abort_i);
  c_last: cover property (byte_valid_o && byte_ready_i && byte_last_o);
endmodule : hied_desc_source_chk

bind hied_desc_source hied_desc_source_chk u_chk (.clk_i, .srst_i, .multi_translator_select_i,
  .start_i, .skip_i, .max_len_i, .abort_i, .byte_ready_i, .byte_valid_o, .byte_data_o,
  .byte_last_o, .busy_o, .total_length_o);

// file: hied_host_model.sv
`timescale 1ns/1ps
module hied_host_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [7:0] got [0:1023];
  int cnt = 0;
  int ends = 0;
  int end_at = 0;
  initial ready_o = 1'b0;
  // Slow host accepts only every other cycle
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
    begin
      got[cnt] = data_i;
      cnt = cnt + 1;
      // Remember where each stream said it ended
      if (last_i)
      begin
        ends = ends + 1;
        end_at = cnt;
      end
    end
    ready_o <= #1 slow_i ? !ready_o : 1'b1;
  end
endmodule : hied_host_model

// file: tb_hub_interface_endpoint_descriptors.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, a, b); end end
module tb_hub_interface_endpoint_descriptors;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sel = 1'b0;
  logic two = 1'b0;
  logic start = 1'b0;
  logic [5:0] skip = 6'h00;
  logic [7:0] len = 8'h00;
  logic abort = 1'b0;
  logic slow = 1'b0;
  logic rdy;
  logic vld;
  logic [7:0] dat;
  logic last;
  logic busy;
  logic [15:0] tot;
  int failures = 0;
  int num_checks = 0;
  hied_desc_source u_dut (.clk_i(clk_i), .srst_i(srst_i), .multi_translator_select_i(sel),
    .two_interfaces_i(two), .start_i(start), .skip_i(skip), .max_len_i(len), .abort_i(abort),
    .byte_ready_i(rdy), .byte_valid_o(vld), .byte_data_o(dat), .byte_last_o(last), .busy_o(busy),
    .total_length_o(tot));
  hied_host_model m (.clk_i(clk_i), .slow_i(slow), .valid_i(vld), .data_i(dat),
    .last_i(last), .ready_o(rdy));
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [7:0] exp_byte(input int i, input logic t);
    logic [7:0] ifd [0:8];
    logic [7:0] epd [0:6];
    ifd = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
    epd = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0c};
    if (i % 16 > 8)
      return epd[i % 16 - 9];
    if (i % 16 == 3)
      return (i > 15) ? 8'h01 : 8'h00;
    if (i % 16 == 7)
      return (i > 15) ? 8'h02 : {7'h00, t};
    return ifd[i % 16];
  endfunction : exp_byte
  task automatic run(input logic s, input logic t, input int k, input int n, input logic w);
    int bs;
    int be;
    int e;
    int i;
    bs = m.cnt;
    be = m.ends;
    e = (s ? 32 : 16) - k;
    e = (n < e) ? n : e;
    @(posedge clk_i) #1;
    sel = s;
    two = t;
    skip = k[5:0];
    len = n[7:0];
    slow = w;
    start = 1'b1;
    @(posedge clk_i) #1;
    start = 1'b0;
    for (i = 0; i < 200 && busy === 1'b1; i++) @(posedge clk_i) #1;
    `CHK(m.cnt - bs, e)
    for (i = 0; i < e; i++) `CHK(m.got[bs + i], exp_byte(k + i, t))
    `CHK(m.ends - be, (e > 0) ? 1 : 0)
    if (e > 0) `CHK(m.end_at - bs, e)
    `CHK(tot, s ? 16'h0029 : 16'h0019)
    $display("stream skip %0d len %0d done", k, n);
  endtask : run
  task automatic t_abort;
    @(posedge clk_i) #1;
    sel = 1'b1;
    skip = 6'h00;
    len = 8'h20;
    slow = 1'b0;
    start = 1'b1;
    @(posedge clk_i) #1;
    start = 1'b0;
    repeat (4) @(posedge clk_i) #1;
    abort = 1'b1;
    @(posedge clk_i) #1;
    abort = 1'b0;
    `CHK(vld, 1'b0)
    $display("abort done");
  endtask : t_abort
  task automatic t_single;
    run(0, 0, 0, 16, 0);
  endtask : t_single
  task automatic t_two_if;
    run(0, 1, 0, 16, 1);
  endtask : t_two_if
  task automatic t_multi;
    run(1, 0, 0, 64, 0);
  endtask : t_multi
  task automatic t_limit;
    run(1, 1, 13, 4, 1);
    run(0, 1, 4, 1, 1);
  endtask : t_limit
  task automatic t_refused;
    run(0, 0, 16, 8, 0);
    run(0, 0, 0, 0, 0);
  endtask : t_refused
  task automatic t_resume;
    run(1, 1, 9, 40, 1);
    run(1, 0, 31, 5, 0);
  endtask : t_resume
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    #25000;
    failures++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_single();
    t_two_if();
    t_multi();
    t_limit();
    t_refused();
    t_abort();
    t_resume();
    give_verdict();
  end
endmodule : tb_hub_interface_endpoint_descriptors
